/* core/sat_transmitter.sv */
// Single-wire angle frame transmitter
`timescale 1ns/10ps
module sat_transmitter #(
  parameter logic [7:0] PAUSE_TICKS = 8'h0C
) (
  // Clock and reset
  input  wire  logic                 clk,
  input  wire  logic                 nrst,
  // Configuration word and measurement
  input  wire  sat_pkg::sat_cfg_t    cfg,
  input  wire  logic [11:0]          angle_in,
  input  wire  logic [11:0]          aux_in,
  input  wire  sat_pkg::sat_stat_t   stat_in,
  // Frame requests and programming mode
  input  wire  logic                 trig,
  input  wire  logic                 addr_hit,
  input  wire  logic                 poll_turn,
  input  wire  logic                 prog_mode,
  // Line and status
  output logic                       sent_out,
  output logic [3:0]                 sent_drive,
  output logic                       frame_busy
);
  import sat_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_NIB, ST_PAUSE} sat_state_t;

  sat_state_t             state;
  logic [CNT_W-1:0]       pre_cnt;
  logic [CNT_W-1:0]       tick_len_q;
  logic [7:0]             tick_cnt;
  logic [7:0]             pulse_ticks;
  logic [2:0]             nib_idx;
  logic [2:0]             last_idx;
  logic                   pause_q;
  logic [3:0]             frame_nib [NIB_SLOTS];
  logic [3:0]             next_nib [NIB_SLOTS];
  logic [3:0]             nib_data [DATA_N_LONG];
  logic [2:0]             n_data;
  logic [3:0]             crc_acc;
  logic                   start_req;
  logic                   tick;
  logic                   pulse_end;
  logic                   frame_done;
  logic                   launch;

  ////////////////////////////////////////////////////////////////////////////
  // Checksum step, one nibble
  function automatic logic [3:0] crc_step(input logic [3:0] c_in, input logic [3:0] d);
    logic [3:0] c;
    logic       fb;
    c = c_in;
    for (int i = 0; i < 4; i++) begin
      fb = c[3];
      c = {c[2:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    return c ^ d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Request selection by mode
  always_comb begin
    case (cfg.sent_mode)
      MODE_STANDARD:  start_req = 1'b1;
      MODE_TRIGGERED: start_req = trig;
      MODE_ADDRESSED: start_req = addr_hit;
      MODE_POLLED:    start_req = poll_turn;
      default:        start_req = 1'b0;
    endcase
  end

  assign tick       = (pre_cnt == tick_len_q - 16'h0001);
  assign pulse_end  = tick && (tick_cnt == pulse_ticks - 8'h01);
  assign frame_done = pulse_end && ((state == ST_PAUSE) ||
                      (state == ST_NIB && nib_idx == last_idx && !pause_q));
  assign launch     = !prog_mode && start_req && (state == ST_IDLE || frame_done);

  ////////////////////////////////////////////////////////////////////////////
  // Next frame contents
  always_comb begin
    nib_data[0] = angle_in[11:8];
    nib_data[1] = angle_in[7:4];
    nib_data[2] = angle_in[3:0];
    nib_data[3] = aux_in[11:8];
    nib_data[4] = aux_in[7:4];
    nib_data[5] = aux_in[3:0];
    n_data = (cfg.data_mode == DATA_ANGLE) ? DATA_N_SHORT : DATA_N_LONG;
    crc_acc = CRC_SEED;
    for (int k = 0; k < DATA_N_LONG; k++) begin
      if (3'(k) < n_data) begin
        crc_acc = crc_step(crc_acc, nib_data[k]);
      end
    end
    crc_acc = crc_step(crc_acc, CRC_AUGMENT);
    for (int k = 0; k < NIB_SLOTS; k++) begin
      next_nib[k] = 4'h0;
    end
    next_nib[0] = {(cfg.serial_mode == SERIAL_NONE) ? 2'b00 : stat_in.serial_bits,
                   stat_in.status};
    for (int k = 0; k < DATA_N_LONG; k++) begin
      if (3'(k) < n_data) begin
        next_nib[k + 1] = nib_data[k];
      end
    end
    next_nib[n_data + 3'h1] = crc_acc;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current pulse length in ticks
  always_comb begin
    case (state)
      ST_SYNC:  pulse_ticks = SYNC_TICKS;
      ST_NIB:   pulse_ticks = LOW_TICKS + NIB_BASE_TICKS + {4'h0, frame_nib[nib_idx]};
      ST_PAUSE: pulse_ticks = PAUSE_TICKS;
      default:  pulse_ticks = SYNC_TICKS;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state   <= ST_IDLE;
      nib_idx <= 3'h0;
    end else if (prog_mode) begin
      state   <= ST_IDLE;
      nib_idx <= 3'h0;
    end else if (launch) begin
      state   <= ST_SYNC;
      nib_idx <= 3'h0;
    end else if (frame_done) begin
      state   <= ST_IDLE;
      nib_idx <= 3'h0;
    end else if (pulse_end) begin
      case (state)
        ST_SYNC: begin
          state   <= ST_NIB;
          nib_idx <= 3'h0;
        end
        ST_NIB: begin
          if (nib_idx == last_idx) begin
            state <= ST_PAUSE;
          end else begin
            nib_idx <= nib_idx + 3'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame latch at launch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_idx   <= 3'h0;
      pause_q    <= 1'b0;
      tick_len_q <= 16'h0001;
      for (int k = 0; k < NIB_SLOTS; k++) begin
        frame_nib[k] <= 4'h0;
      end
    end else if (launch) begin
      last_idx   <= n_data + 3'h1;
      pause_q    <= cfg.pause_en;
      tick_len_q <= 16'((32'(cfg.tick_time) + 32'd1) * TICK_UNIT_CYC);
      for (int k = 0; k < NIB_SLOTS; k++) begin
        frame_nib[k] <= next_nib[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tick prescaler and tick counter
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pre_cnt  <= 16'h0000;
      tick_cnt <= 8'h00;
    end else if (prog_mode || launch || state == ST_IDLE) begin
      pre_cnt  <= 16'h0000;
      tick_cnt <= 8'h00;
    end else if (tick) begin
      pre_cnt  <= 16'h0000;
      tick_cnt <= pulse_end ? 8'h00 : tick_cnt + 8'h01;
    end else begin
      pre_cnt  <= pre_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line driver
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sent_out   <= 1'b1;
      sent_drive <= 4'h0;
      frame_busy <= 1'b0;
    end else begin
      sent_out   <= prog_mode || state == ST_IDLE || tick_cnt >= LOW_TICKS;
      sent_drive <= cfg.drive;
      frame_busy <= !prog_mode && state != ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [CNT_W-1:0] low_run;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_run <= 16'h0000;
    end else begin
      low_run <= sent_out ? 16'h0000 : low_run + 16'h0001;
    end
  end

  a_low_width: assert property (@(posedge clk) disable iff (!nrst)
    $rose(sent_out) && !$past(prog_mode) |-> low_run == 16'(32'(LOW_TICKS) * tick_len_q))
    else $error("low interval not five ticks");

  a_prog_abort: assert property (@(posedge clk) disable iff (!nrst)
    prog_mode |=> sent_out && !frame_busy && state == ST_IDLE)
    else $error("frame not abandoned on programming entry");

  a_std_stream: assert property (@(posedge clk) disable iff (!nrst)
    state == ST_IDLE && cfg.sent_mode == MODE_STANDARD && !prog_mode |=> state == ST_SYNC)
    else $error("standard mode did not start a frame");

  a_trig_only: assert property (@(posedge clk) disable iff (!nrst)
    state == ST_IDLE && cfg.sent_mode == MODE_TRIGGERED && !trig |=> state == ST_IDLE)
    else $error("triggered mode sent without trigger");

  a_shared_wait: assert property (@(posedge clk) disable iff (!nrst)
    state == ST_IDLE && ((cfg.sent_mode == MODE_ADDRESSED && !addr_hit) ||
    (cfg.sent_mode == MODE_POLLED && !poll_turn)) |=> state == ST_IDLE)
    else $error("shared mode sent without address or poll");

  a_sync_first: assert property (@(posedge clk) disable iff (!nrst)
    state == ST_IDLE ##1 state != ST_IDLE |-> state == ST_SYNC ##1 !sent_out)
    else $error("frame did not open with sync pulse");

  a_frame_order: assert property (@(posedge clk) disable iff (!nrst || prog_mode)
    state == ST_SYNC && pulse_end && !launch |=> state == ST_NIB && nib_idx == 3'h0)
    else $error("status nibble does not follow sync");

  a_pause_crc: assert property (@(posedge clk) disable iff (!nrst || prog_mode)
    state == ST_NIB && pulse_end && nib_idx == last_idx && pause_q |=> state == ST_PAUSE)
    else $error("pause pulse missing after checksum");

  a_angle_load: assert property (@(posedge clk) disable iff (!nrst)
    launch |=> {frame_nib[1], frame_nib[2], frame_nib[3]} == $past(angle_in))
    else $error("angle code not loaded in data nibbles");

  a_status_load: assert property (@(posedge clk) disable iff (!nrst)
    launch |=> frame_nib[0][1:0] == $past(stat_in.status))
    else $error("status bits not in status nibble");

  a_tick_period: assert property (@(posedge clk) disable iff (!nrst)
    launch |=> tick_len_q == 16'((32'($past(cfg.tick_time)) + 32'd1) * TICK_UNIT_CYC))
    else $error("tick period not from tick-time field");

  a_drive_follow: assert property (@(posedge clk) disable iff (!nrst)
    ##1 sent_drive == $past(cfg.drive))
    else $error("drive setting not applied");

  // Cycles since the last falling line edge
  logic             sent_q;
  logic [CNT_W-1:0] fall_gap;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sent_q   <= 1'b1;
      fall_gap <= 16'h0000;
    end else begin
      sent_q   <= sent_out;
      fall_gap <= (sent_q && !sent_out) ? 16'h0001 : fall_gap + 16'h0001;
    end
  end

  a_sync_len: assert property (@(posedge clk) disable iff (!nrst || prog_mode)
    state == ST_SYNC && pulse_end |-> ##2
    fall_gap == 16'(32'(SYNC_TICKS) * 32'($past(tick_len_q, 2))))
    else $error("sync pulse length wrong");

  a_nib_len: assert property (@(posedge clk) disable iff (!nrst || prog_mode)
    state == ST_NIB && pulse_end |-> ##2 fall_gap == 16'((32'(LOW_TICKS) +
    32'(NIB_BASE_TICKS) + 32'($past(frame_nib[nib_idx], 2))) * 32'($past(tick_len_q, 2))))
    else $error("nibble pulse length wrong");

  a_pause_len: assert property (@(posedge clk) disable iff (!nrst || prog_mode)
    state == ST_PAUSE && pulse_end |-> ##2
    fall_gap == 16'(32'(PAUSE_TICKS) * 32'($past(tick_len_q, 2))))
    else $error("pause pulse length wrong");

  a_aux_load: assert property (@(posedge clk) disable iff (!nrst)
    launch && cfg.data_mode != DATA_ANGLE |=>
    {frame_nib[4], frame_nib[5], frame_nib[6]} == $past(aux_in))
    else $error("optional data not loaded in data nibbles");

  c_std_frame:  cover property (@(posedge clk) disable iff (!nrst)
    frame_done && cfg.sent_mode == MODE_STANDARD);
  c_trig_frame: cover property (@(posedge clk) disable iff (!nrst)
    launch && cfg.sent_mode == MODE_TRIGGERED);
  c_pause_sent: cover property (@(posedge clk) disable iff (!nrst)
    state == ST_PAUSE && pulse_end);
  c_abort_mid:  cover property (@(posedge clk) disable iff (!nrst)
    prog_mode && state == ST_NIB);
  c_long_frm:   cover property (@(posedge clk) disable iff (!nrst)
    launch && cfg.data_mode != DATA_ANGLE);

endmodule // sat_transmitter

/* core/sat_pkg.sv */
// Constants, configuration layout and types for the angle frame transmitter
package sat_pkg;

  // Non-volatile word addresses
  localparam logic [7:0] ADDR_LOW_POWER_TIMING  = 8'h15;
  localparam logic [7:0] ADDR_LOW_POWER_ANGLE   = 8'h16;
  localparam logic [7:0] ADDR_OUTPUT_CONFIG     = 8'h17;
  localparam logic [7:0] ADDR_CUSTOMER_ONE      = 8'h18;
  localparam logic [7:0] ADDR_CUSTOMER_TWO      = 8'h19;
  localparam logic [7:0] ADDR_ERROR_MASK        = 8'h1E;
  localparam logic [7:0] ADDR_CUSTOMER_SCRATCH  = 8'h1F;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned TICK_UNIT_NS  = 1000;
  localparam int unsigned TICK_UNIT_CYC = (TICK_UNIT_NS / CLK_PERIOD_NS < 1) ? 1 :
                                          TICK_UNIT_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 16;
  localparam logic [7:0]  LOW_TICKS      = 8'h05;
  localparam logic [7:0]  NIB_BASE_TICKS = 8'h07;
  localparam logic [7:0]  SYNC_TICKS     = 8'h38;

  // Angle code and checksum
  localparam logic [11:0] ANGLE_FSO_MAX = 12'hFFF;
  localparam logic [3:0]  CRC_SEED      = 4'h5;
  localparam logic [3:0]  CRC_POLY      = 4'hD;
  localparam logic [3:0]  CRC_AUGMENT   = 4'h0;

  // Frame shape
  localparam int unsigned NIB_SLOTS     = 8;
  localparam logic [2:0]  DATA_N_SHORT  = 3'h3;
  localparam logic [2:0]  DATA_N_LONG   = 3'h6;

  // Mode and format codes
  localparam logic [2:0] MODE_STANDARD  = 3'h0;
  localparam logic [2:0] MODE_TRIGGERED = 3'h1;
  localparam logic [2:0] MODE_ADDRESSED = 3'h2;
  localparam logic [2:0] MODE_POLLED    = 3'h3;
  localparam logic [2:0] DATA_ANGLE     = 3'h0;
  localparam logic [2:0] SERIAL_NONE    = 3'h0;

  // Output-configuration word, bit 23 first
  typedef struct packed {
    logic       opt23;
    logic       opt22;
    logic       opt21;
    logic       pause_en;
    logic       opt19;
    logic       rsvd;
    logic [2:0] serial_mode;
    logic [2:0] data_mode;
    logic [2:0] sent_mode;
    logic [4:0] tick_time;
    logic [3:0] drive;
  } sat_cfg_t;

  // Device status carried in the status nibble
  typedef struct packed {
    logic [1:0] serial_bits;
    logic [1:0] status;
  } sat_stat_t;

endpackage

/* bench/sat_rx_model.sv */
// Receiver model that times line pulses in ticks
`timescale 1ns/10ps
module sat_rx_model (
  // Clock and reset
  input wire logic        clk,
  input wire logic        nrst,
  // Line, frame marker and tick length
  input wire logic        line,
  input wire logic        busy,
  input wire logic [15:0] tcyc
);
  int   ticks_q[$];
  int   low_err = 0;
  int   cnt;
  int   t;
  bit   armed;
  logic line_d;
  logic busy_d;

  ////////////////////////////////////////////////////////////////////////////
  // Pulse timing from falling edge to the next falling edge, or to the fall of busy for the last pulse
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt = 0;
      armed = 0;
      line_d = 1'b1;
      busy_d = 1'b0;
    end else begin
      t = int'(tcyc);
      cnt++;
      if (line_d && !line) begin
        if (armed)
          ticks_q.push_back((cnt + t / 2) / t);
        cnt = 0;
        armed = 1;
      end
      if (!line_d && line && armed && cnt != 5 * t)
        low_err++;
      if (busy_d && !busy && armed) begin
        ticks_q.push_back((cnt + t / 2) / t);
        armed = 0;
      end
      line_d = line;
      busy_d = busy;
    end
  end
endmodule // sat_rx_model

/* bench/tb.sv */
// Testbench for the angle frame transmitter
`timescale 1ns/10ps
module tb;
  import sat_pkg::*;
  localparam logic [7:0] PT = 8'h0C;
  logic        clk, nrst, trig, addr_hit, poll_turn, prog_mode;
  logic        sent_out, frame_busy;
  logic [3:0]  sent_drive;
  logic [11:0] angle_in, aux_in;
  logic [15:0] tcyc;
  sat_cfg_t    cfg;
  sat_stat_t   stat_in;
  int          num_errors, cmp_count;
  int          exp_q[$];

  sat_transmitter #(.PAUSE_TICKS(PT)) dut (.clk(clk), .nrst(nrst), .cfg(cfg),
    .angle_in(angle_in), .aux_in(aux_in), .stat_in(stat_in), .trig(trig),
    .addr_hit(addr_hit), .poll_turn(poll_turn), .prog_mode(prog_mode),
    .sent_out(sent_out), .sent_drive(sent_drive), .frame_busy(frame_busy));
  sat_rx_model rx (.clk(clk), .nrst(nrst), .line(sent_out), .busy(frame_busy), .tcyc(tcyc));

  ////////////////////////////////////////////////////////////////////////////
  // Checking and expected frames
  task automatic check(input bit ok, input string msg);
    cmp_count++;
    if (!ok) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic int crc_step(input int c, input int nib);
    for (int i = 0; i < 4; i++)
      c = ((c << 1) & 15) ^ ((c & 8) ? 13 : 0);
    return c ^ nib;
  endfunction

  task automatic add_frame();
    int d[$];
    int c = 5;
    for (int i = 2; i >= 0; i--) d.push_back(int'(angle_in[4*i +: 4]));
    if (cfg.data_mode != DATA_ANGLE)
      for (int i = 2; i >= 0; i--) d.push_back(int'(aux_in[4*i +: 4]));
    exp_q.push_back(56);
    exp_q.push_back(12 + int'({(cfg.serial_mode == SERIAL_NONE) ? 2'b00 :
                    stat_in.serial_bits, stat_in.status}));
    foreach (d[i]) begin
      exp_q.push_back(12 + d[i]);
      c = crc_step(c, d[i]);
    end
    exp_q.push_back(12 + crc_step(c, 0));
    if (cfg.pause_en)
      exp_q.push_back(int'(PT));
  endtask

  task automatic cmp_frames();
    check(rx.ticks_q.size() == exp_q.size(), "pulse count");
    foreach (exp_q[i])
      if (i < rx.ticks_q.size()) check(rx.ticks_q[i] == exp_q[i], "pulse ticks");
    check(rx.low_err == 0, "low interval length");
    rx.ticks_q.delete();
    exp_q.delete();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus helpers
  task automatic setup(input logic [2:0] m, input logic [2:0] dm, input logic pz,
                       input logic [4:0] tt, input logic [11:0] ang);
    sat_cfg_t c;
    c = sat_cfg_t'(24'($urandom));
    c.sent_mode = m;
    c.data_mode = dm;
    c.pause_en = pz;
    c.tick_time = tt;
    @(posedge clk);
    cfg <= c;
    angle_in <= ang;
    aux_in <= 12'($urandom);
    stat_in <= sat_stat_t'(4'($urandom));
    tcyc <= 16'((int'(tt) + 1) * 25);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check(sent_drive === c.drive, "drive code");
  endtask

  task automatic fire(input logic [2:0] m);
    @(posedge clk);
    trig <= (m == MODE_TRIGGERED);
    addr_hit <= (m == MODE_ADDRESSED);
    poll_turn <= (m == MODE_POLLED);
    @(posedge clk);
    trig <= 1'b0;
    addr_hit <= 1'b0;
    poll_turn <= 1'b0;
  endtask

  task automatic wait_busy(input logic v);
    for (int n = 0; n < 20000 && frame_busy !== v; n++) @(negedge clk);
    check(frame_busy === v, "frame busy wait");
  endtask

  task automatic run(input logic [2:0] m, input logic [2:0] dm, input logic pz,
                     input logic [4:0] tt, input logic [11:0] ang);
    setup(m, dm, pz, tt, ang);
    add_frame();
    repeat (100) @(negedge clk);
    check(frame_busy === 1'b0, "frame without request");
    fire(m);
    wait_busy(1'b1);
    repeat (300) @(posedge clk);
    fire(m);
    wait_busy(1'b0);
    repeat (2) @(posedge clk);
    cmp_frames();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Clock, watchdog and main sequence
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (90000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial begin
    {nrst, trig, addr_hit, poll_turn, prog_mode} = 5'h00;
    cfg = '0;
    cfg.sent_mode = MODE_TRIGGERED;
    angle_in = 12'h000;
    aux_in = 12'h000;
    stat_in = '0;
    tcyc = 16'h0019;
    void'($urandom(42686));
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    run(MODE_TRIGGERED, DATA_ANGLE, 1'b0, 5'h00, 12'hFFF);
    run(MODE_ADDRESSED, 3'h1, 1'b1, 5'h01, 12'($urandom));
    run(MODE_POLLED, DATA_ANGLE, 1'b1, 5'h00, 12'h000);
    setup(MODE_STANDARD, DATA_ANGLE, 1'b1, 5'h00, 12'($urandom));
    add_frame();
    add_frame();
    wait_busy(1'b1);
    for (int n = 0; n < 20000 && rx.ticks_q.size() < 8; n++) @(posedge clk);
    cfg.sent_mode <= 3'h7;
    wait_busy(1'b0);
    repeat (2) @(posedge clk);
    cmp_frames();
    setup(MODE_TRIGGERED, 3'h1, 1'b0, 5'h01, 12'($urandom));
    fire(MODE_TRIGGERED);
    wait_busy(1'b1);
    repeat (500) @(posedge clk);
    prog_mode <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check(sent_out === 1'b1 && frame_busy === 1'b0, "abort on programming");
    fire(MODE_TRIGGERED);
    repeat (50) @(negedge clk);
    check(frame_busy === 1'b0 && sent_out === 1'b1, "frame while programming");
    print_verdict();
  end
endmodule // tb
